/* src/ssr_scan_ctrl.v */
// Scanning converter sequencer, result store, flags and APB slave
`timescale 1ns/10ps
`include "ssr_consts.vh"
module ssr_scan_ctrl (
  // Clock, reset, enable
  input wire mclk,
  input wire rst_b,
  input wire clkEn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Trigger and analog core
  input wire startTrig,
  input wire [11:0] convData,
  // Status outputs
  output reg sampleDone,
  output reg endOfScan,
  output reg dmaReq,
  output reg irqOut,
  output reg delayedConvClk
);
  localparam ST_IDLE = 2'd0;
  localparam ST_DELAY = 2'd1;
  localparam ST_CONV = 2'd2;

  // Lowest enabled channel at or above s; 16 when none
  function [4:0] next_ch;
    input [15:0] m;
    input [4:0] s;
    integer i;
    begin
      next_ch = 5'h10;
      for (i = 15; i >= 0; i = i - 1) begin
        if (m[i] && (i >= s)) begin
          next_ch = i[4:0];
        end
      end
    end
  endfunction

  // Configuration
  reg hwMode_q;
  reg contMode_q;
  reg syncEn_q;
  reg fwStart_q;
  reg [7:0] sampleTime_q;
  reg [7:0] halfDiv_q;
  reg [15:0] chanEn_q;
  reg [15:0] limLow_q;
  reg [15:0] limHigh_q;
  reg [1:0] cmpMode_q;
  reg [3:0] intrMask_q;
  reg [15:0] satMask_q;
  reg [15:0] rngMask_q;
  // Flags and results
  reg [3:0] intr_q;
  reg [15:0] sat_q;
  reg [15:0] rng_q;
  reg [15:0] valid_q;
  reg [15:0] work_q [0:15];
  reg [15:0] res_q [0:15];
  // Sequencer
  reg [1:0] state_q;
  reg [9:0] dly_q;
  reg [8:0] cnt_q;
  reg [3:0] ch_q;
  reg pendStart_q;
  reg pendHw_q;
  reg pendFw_q;
  reg curHw_q;
  reg curFw_q;
  // Sample clock
  reg [7:0] divCnt_q;
  reg aclk_q;
  // Trigger capture and synchroniser
  reg cap1_q;
  reg cap2_q;
  reg sync1_q;
  reg sync2_q;
  reg sync3_q;
  reg sync4_q;
  reg [31:0] rdData;
  reg rdHit;
  integer k;

  wire setupPh = psel & ~penable;
  wire [3:0] rdIdx = paddr[5:2];
  wire wrEn = psel & penable & pwrite & pready & ~pslverr;
  wire [3:0] intrClr = (wrEn && paddr == `SSR_A_INTR) ? pwdata[3:0] : 4'h0;
  wire [15:0] satClr = (wrEn && paddr == `SSR_A_SAT) ? pwdata[15:0] : 16'h0;
  wire [15:0] rngClr = (wrEn && paddr == `SSR_A_RNG) ? pwdata[15:0] : 16'h0;

  wire [3:0] intrMasked = intr_q & intrMask_q;
  wire [15:0] satMasked = sat_q & satMask_q;
  wire [15:0] rngMasked = rng_q & rngMask_q;

  wire divWrap = ({1'b0, divCnt_q} + 9'h001) >= {1'b0, halfDiv_q};
  wire aclkRise = divWrap & ~aclk_q;

  // Sync path adds two cycles over the direct capture path
  wire edgeDirect = cap1_q & ~cap2_q;
  wire edgeSync = sync3_q & ~sync4_q;
  wire hwEdge = hwMode_q & (syncEn_q ? edgeSync : edgeDirect);
  wire startReq = hwEdge | fwStart_q;
  wire busy = (state_q != ST_IDLE);

  wire [8:0] cntNx = cnt_q + 9'h001;
  wire [8:0] convEnd = {1'b0, sampleTime_q} + `SSR_CONV_EXTRA;
  wire inConv = (state_q == ST_CONV) & aclkRise;
  wire sampEnd = inConv & (cntNx == {1'b0, sampleTime_q});
  wire convDone = inConv & (cntNx == convEnd);
  wire [4:0] nxCh = next_ch(chanEn_q, {1'b0, ch_q} + 5'h01);
  wire [4:0] firstCh = next_ch(chanEn_q, 5'h00);
  wire scanEnd = convDone & nxCh[4];
  wire [15:0] newVal = {4'h0, convData};
  wire rawSat = (convData == `SSR_RAW_MIN) | (convData == `SSR_RAW_MAX);
  wire belowLo = newVal < limLow_q;
  wire aboveHi = newVal > limHigh_q;
  reg rngHit;
  always @* begin
    case (cmpMode_q)
      2'd0: rngHit = belowLo;
      2'd1: rngHit = ~belowLo & ~aboveHi;
      2'd2: rngHit = aboveHi;
      default: rngHit = belowLo | aboveHi;
    endcase
  end
  // Queued start or continuous mode rescans at once
  wire restart = scanEnd & (contMode_q | pendStart_q);

  wire [15:0] chOne = 16'h0001 << ch_q;
  // Collision bits belong to the scan now ending
  // Overflow takes the old pending bit
  wire [3:0] intrSet = scanEnd ? {curHw_q, curFw_q, intr_q[0], 1'b1} : 4'h0;
  wire [15:0] satSet = (convDone & rawSat) ? chOne : 16'h0;
  wire [15:0] rngSet = (convDone & rngHit) ? chOne : 16'h0;

  // Register read decode
  always @* begin
    rdData = 32'h0;
    rdHit = 1'b1;
    if (paddr[11:6] == 6'h02) begin
      rdData = {valid_q[rdIdx], rng_q[rdIdx], sat_q[rdIdx], 13'h0,
        res_q[rdIdx]};
      rdHit = (paddr[1:0] == 2'b00);
    end else begin
      case (paddr)
        `SSR_A_CTRL: rdData = {28'h0, syncEn_q, contMode_q, hwMode_q, 1'b0};
        `SSR_A_TIMING: rdData = {16'h0, halfDiv_q, sampleTime_q};
        `SSR_A_CHAN_EN: rdData = {16'h0, chanEn_q};
        `SSR_A_LIMITS: rdData = {limHigh_q, limLow_q};
        `SSR_A_COMPARE: rdData = {30'h0, cmpMode_q};
        `SSR_A_STATUS: rdData = {26'h0, pendStart_q, ch_q, busy};
        `SSR_A_INTR: rdData = {28'h0, intr_q};
        `SSR_A_INTR_MASK: rdData = {28'h0, intrMask_q};
        `SSR_A_INTR_MASKED: rdData = {28'h0, intrMasked};
        `SSR_A_SAT: rdData = {16'h0, sat_q};
        `SSR_A_SAT_MASK: rdData = {16'h0, satMask_q};
        `SSR_A_SAT_MASKED: rdData = {16'h0, satMasked};
        `SSR_A_RNG: rdData = {16'h0, rng_q};
        `SSR_A_RNG_MASK: rdData = {16'h0, rngMask_q};
        `SSR_A_RNG_MASKED: rdData = {16'h0, rngMasked};
        default: rdHit = 1'b0;
      endcase
    end
  end

  // APB handshake and configuration
  always @(posedge mclk) begin
    if (!rst_b) begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      hwMode_q <= 1'b0;
      contMode_q <= 1'b0;
      syncEn_q <= 1'b1;
      fwStart_q <= 1'b0;
      sampleTime_q <= `SSR_RST_SAMPLE;
      halfDiv_q <= `SSR_RST_HALFDIV;
      chanEn_q <= `SSR_RST_CHAN_EN;
      limLow_q <= 16'h0000;
      limHigh_q <= `SSR_RST_LIM_HIGH;
      cmpMode_q <= 2'd0;
      intrMask_q <= `SSR_RST_INTR_MASK;
      satMask_q <= 16'h0;
      rngMask_q <= 16'h0;
    end else if (clkEn) begin
      pready <= setupPh;
      pslverr <= setupPh & ~rdHit;
      fwStart_q <= 1'b0;
      if (setupPh) begin
        prdata <= (pwrite || !rdHit) ? 32'h0 : rdData;
      end
      if (wrEn) begin
        case (paddr)
          `SSR_A_CTRL: begin
            fwStart_q <= pwdata[`SSR_CTRL_START];
            hwMode_q <= pwdata[`SSR_CTRL_HWMODE];
            contMode_q <= pwdata[`SSR_CTRL_CONT];
            syncEn_q <= pwdata[`SSR_CTRL_SYNC];
          end
          `SSR_A_TIMING: begin
            sampleTime_q <= pwdata[7:0];
            halfDiv_q <= pwdata[15:8];
          end
          `SSR_A_CHAN_EN: chanEn_q <= pwdata[15:0];
          `SSR_A_LIMITS: begin
            limLow_q <= pwdata[15:0];
            limHigh_q <= pwdata[31:16];
          end
          `SSR_A_COMPARE: cmpMode_q <= pwdata[1:0];
          `SSR_A_INTR_MASK: intrMask_q <= pwdata[3:0];
          `SSR_A_SAT_MASK: satMask_q <= pwdata[15:0];
          `SSR_A_RNG_MASK: rngMask_q <= pwdata[15:0];
          default: ;
        endcase
      end
    end
  end

  // Sample clock divider and delayed converter clock
  always @(posedge mclk) begin
    if (!rst_b) begin
      divCnt_q <= 8'h00;
      aclk_q <= 1'b0;
      delayedConvClk <= 1'b0;
    end else if (clkEn) begin
      divCnt_q <= divWrap ? 8'h00 : divCnt_q + 8'h01;
      if (divWrap) begin
        aclk_q <= ~aclk_q;
      end
      delayedConvClk <= aclk_q;
    end
  end

  // Trigger capture
  always @(posedge mclk) begin
    if (!rst_b) begin
      cap1_q <= 1'b0;
      cap2_q <= 1'b0;
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      sync3_q <= 1'b0;
      sync4_q <= 1'b0;
    end else if (clkEn) begin
      cap1_q <= startTrig;
      cap2_q <= cap1_q;
      sync1_q <= startTrig;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      sync4_q <= sync3_q;
    end
  end

  // Sequencer
  always @(posedge mclk) begin
    if (!rst_b) begin
      state_q <= ST_IDLE;
      dly_q <= 10'h0;
      cnt_q <= 9'h0;
      ch_q <= 4'h0;
      pendStart_q <= 1'b0;
      pendHw_q <= 1'b0;
      pendFw_q <= 1'b0;
      curHw_q <= 1'b0;
      curFw_q <= 1'b0;
      sampleDone <= 1'b0;
      endOfScan <= 1'b0;
      dmaReq <= 1'b0;
    end else if (clkEn) begin
      sampleDone <= sampEnd;
      endOfScan <= scanEnd;
      dmaReq <= convDone;
      if (busy && startReq) begin
        pendStart_q <= 1'b1;
        pendHw_q <= pendHw_q | hwEdge;
        pendFw_q <= pendFw_q | (fwStart_q & hwMode_q);
      end
      case (state_q)
        ST_IDLE: begin
          if (startReq && chanEn_q != 16'h0) begin
            state_q <= ST_DELAY;
            dly_q <= `SSR_START_DLY + {1'b0, halfDiv_q, 1'b0};
            curHw_q <= 1'b0;
            curFw_q <= 1'b0;
          end
        end
        ST_DELAY: begin
          if (dly_q == 10'h0) begin
            state_q <= ST_CONV;
            ch_q <= firstCh[3:0];
            cnt_q <= 9'h0;
          end else begin
            dly_q <= dly_q - 10'h001;
          end
        end
        ST_CONV: begin
          if (convDone && !nxCh[4]) begin
            ch_q <= nxCh[3:0];
            cnt_q <= 9'h0;
          end else if (restart && !firstCh[4]) begin
            ch_q <= firstCh[3:0];
            cnt_q <= 9'h0;
            curHw_q <= pendHw_q;
            curFw_q <= pendFw_q;
            pendStart_q <= 1'b0;
            pendHw_q <= 1'b0;
            pendFw_q <= 1'b0;
          end else if (scanEnd) begin
            state_q <= ST_IDLE;
            curHw_q <= 1'b0;
            curFw_q <= 1'b0;
            pendStart_q <= 1'b0;
            pendHw_q <= 1'b0;
            pendFw_q <= 1'b0;
          end else if (aclkRise) begin
            cnt_q <= cntNx;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Flags, a set beats a same-cycle clear
  always @(posedge mclk) begin
    if (!rst_b) begin
      intr_q <= 4'h0;
      sat_q <= 16'h0;
      rng_q <= 16'h0;
    end else if (clkEn) begin
      intr_q <= (intr_q & ~intrClr) | intrSet;
      sat_q <= (sat_q & ~satClr) | satSet;
      rng_q <= (rng_q & ~rngClr) | rngSet;
    end
  end

  // Interrupt output from all masked views
  always @(posedge mclk) begin
    if (!rst_b) begin
      irqOut <= 1'b0;
    end else if (clkEn) begin
      irqOut <= (|intrMasked) | (|satMasked) | (|rngMasked);
    end
  end

  // Working storage and result words
  always @(posedge mclk) begin
    if (!rst_b) begin
      valid_q <= 16'h0;
      for (k = 0; k < 16; k = k + 1) begin
        work_q[k] <= 16'h0;
        res_q[k] <= 16'h0;
      end
    end else if (clkEn) begin
      if (convDone) begin
        work_q[ch_q] <= newVal;
      end
      if (scanEnd) begin
        for (k = 0; k < 16; k = k + 1) begin
          if (chanEn_q[k]) begin
            res_q[k] <= (k == ch_q) ? newVal : work_q[k];
            valid_q[k] <= 1'b1;
          end
        end
      end
    end
  end
endmodule

/* src/ssr_consts.vh */
// Register map, field positions, reset values and timing counts
// Notes on behaviour
// - Start sampled on edge; converts 3 cycles plus one sample period later.
// - Clearing synchroniser enable removes two cycles of trigger latency.
// - Conversion ends sample time plus 14 sample periods after it begins.
// - Delayed converter clock: 50% duty, tracks sample clock, lags one cycle.
// - Sample-done pulses when the sample window of the current channel ends.
// - Continuous mode pulses end-of-scan after last channel, then rescans.
// - Result word: data 15:0, saturate 29, range 30, valid 31.
// - Results leave working storage only after all enabled channels sampled.
// - Channel results at consecutive words: base plus channel times four.
// - Pulse DMA request at each end of conversion; word reads only.
// - Interrupt output high when any flag AND mask is non-zero.
// - Zero mask bit removes its source from the interrupt output.
// - Masked view reads flags AND masks.
// - Writing one to a flag clears it.
// - End-of-scan flag bit 0 set when a scan completes.
// - Overflow flag bit 1 set when end-of-scan sets while still pending.
// - Firmware start while busy in hardware mode flags bit 2 at its end.
// - Hardware trigger while busy flags bit 3 when its scan completes.
// - Per-channel saturate flag set when raw result is 0x000 or 0xfff.
// - Per-channel range flag set when result meets limit compare condition.
// - Saturate masked view is flags AND masks; non-zero raises interrupt.
// - Range masked view is flags AND masks; non-zero raises interrupt.
`ifndef SSR_CONSTS_VH
`define SSR_CONSTS_VH
`define SSR_A_CTRL 12'h000
`define SSR_A_TIMING 12'h004
`define SSR_A_CHAN_EN 12'h008
`define SSR_A_LIMITS 12'h00c
`define SSR_A_COMPARE 12'h010
`define SSR_A_STATUS 12'h014
`define SSR_A_INTR 12'h020
`define SSR_A_INTR_MASK 12'h024
`define SSR_A_INTR_MASKED 12'h028
`define SSR_A_SAT 12'h030
`define SSR_A_SAT_MASK 12'h034
`define SSR_A_SAT_MASKED 12'h038
`define SSR_A_RNG 12'h040
`define SSR_A_RNG_MASK 12'h044
`define SSR_A_RNG_MASKED 12'h048
`define SSR_A_RESULT 12'h080
`define SSR_CTRL_START 0
`define SSR_CTRL_HWMODE 1
`define SSR_CTRL_CONT 2
`define SSR_CTRL_SYNC 3
`define SSR_BIT_SAT 29
`define SSR_BIT_RNG 30
`define SSR_BIT_VALID 31
`define SSR_RST_HALFDIV 8'h01
`define SSR_RST_SAMPLE 8'h04
`define SSR_RST_INTR_MASK 4'hf
`define SSR_RST_CHAN_EN 16'h0001
`define SSR_RST_LIM_HIGH 16'hffff
`define SSR_CONV_EXTRA 9'h00e
`define SSR_START_DLY 10'h002
`define SSR_RAW_MIN 12'h000
`define SSR_RAW_MAX 12'hfff
`endif

/* tb/ssr_scan_ctrl_properties.sv */
// Port-level checks on the scan controller
`timescale 1ns/10ps
module ssr_scan_ctrl_checker (
  // Clock and reset
  input wire mclk,
  input wire rst_b,
  input wire clkEn,
  // APB
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // Status
  input wire sampleDone,
  input wire endOfScan,
  input wire dmaReq,
  input wire irqOut,
  input wire delayedConvClk
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!rst_b || !clkEn);
  sequence apbSetup;
    psel && !penable;
  endsequence
  sequence readDone(logic [11:0] a);
    psel && penable && pready && !pwrite && paddr == a;
  endsequence
  a_apb_one_wait: assert property (apbSetup |=> pready)
    else $error("pready not one cycle after setup");
  a_result_no_err: assert property (apbSetup ##0
    (paddr[11:6] == 6'h02 && paddr[1:0] == 2'h0) |=> !pslverr)
    else $error("result word refused");
  a_scan_masked_irq: assert property
    (readDone(12'h028) ##0 (prdata != 32'h0) |-> irqOut)
    else $error("masked scan flags without irq");
  a_sat_masked_irq: assert property
    (readDone(12'h038) ##0 (prdata != 32'h0) |-> irqOut)
    else $error("masked saturate flags without irq");
  a_rng_masked_irq: assert property
    (readDone(12'h048) ##0 (prdata != 32'h0) |-> irqOut)
    else $error("masked range flags without irq");
  a_sdone_one_cycle: assert property (sampleDone |=> !sampleDone)
    else $error("sample done too long");
  a_eos_one_cycle: assert property (endOfScan |=> !endOfScan)
    else $error("end of scan too long");
  a_dma_pulse_only: assert property (dmaReq |=> !dmaReq)
    else $error("dma request not a pulse");
  a_conv_clk_duty: assert property ($rose(delayedConvClk) |=>
    $fell(delayedConvClk) ##1 $rose(delayedConvClk))
    else $error("converter clock duty wrong");
  a_conv_length: assert property (sampleDone |-> ##[28:30] dmaReq)
    else $error("conversion length wrong");
endmodule
bind ssr_scan_ctrl ssr_scan_ctrl_checker chk (.mclk, .rst_b, .clkEn, .psel,
  .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .sampleDone,
  .endOfScan, .dmaReq, .irqOut, .delayedConvClk);

/* tb/ssr_conv_model.sv */
// Converter core stand-in giving one raw result per conversion
`timescale 1ns/10ps
module ssr_conv_model (
  // Clock and reset
  input wire mclk,
  input wire rst_b,
  // Converter side
  input wire dmaReq,
  output logic [11:0] convData
);
  logic [7:0] convIdx_q;
  always @(posedge mclk) begin
    convIdx_q <= !rst_b ? 8'h00 : convIdx_q + {7'h00, dmaReq};
  end
  // Both rail codes first, then mid-scale codes
  always_comb begin
    if (convIdx_q == 8'h00)
      convData = 12'h000;
    else if (convIdx_q == 8'h01)
      convData = 12'hfff;
    else
      convData = 12'h5a0 + {4'h0, convIdx_q};
  end
endmodule

/* tb/ssr_scan_ctrl_bench.sv */
// Self-checking bench for the scan controller
`timescale 1ns/10ps
module ssr_scan_ctrl_bench;
  logic mclk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0;
  logic startTrig = 0, err, clkEn = 1;
  logic [11:0] paddr = 0, convData;
  logic [31:0] pwdata = 0, prdata, rd;
  logic pready, pslverr, sampleDone, endOfScan, dmaReq, irqOut;
  logic delayedConvClk;
  int errors = 0, samples_checked = 0, convCnt = 0, eosCnt = 0, cyc = 0;
  always #2 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    convCnt <= convCnt + dmaReq;
    eosCnt <= eosCnt + endOfScan;
  end
  ssr_scan_ctrl dut (.mclk, .rst_b, .clkEn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .startTrig,
    .convData, .sampleDone, .endOfScan, .dmaReq, .irqOut,
    .delayedConvClk);
  ssr_conv_model core (.mclk, .rst_b, .dmaReq, .convData);
  task automatic check(input logic [31:0] got, exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a,
      input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1 && n++ < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) check(pready, 1'b1);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(rd, e);
  endtask
  task automatic waitEos(input int target);
    int n;
    n = 0;
    while (eosCnt < target && n++ < 3000) @(posedge mclk);
    if (eosCnt < target) check(eosCnt, target);
  endtask
  task automatic t_reset;
    logic v;
    rdchk(12'h024, 32'hf);
    rdchk(12'h034, 32'h0);
    rdchk(12'h044, 32'h0);
    rdchk(12'h020, 32'h0);
    apb(1'b0, 12'h0fc, 32'h0);
    check(err, 1'b1);
    clkEn <= 1'b0;
    @(posedge mclk);
    v = delayedConvClk;
    repeat (4) @(posedge mclk);
    check(delayedConvClk, v);
    clkEn <= 1'b1;
    $display("reset values checked");
  endtask
  task automatic t_scan;
    wr(12'h034, 32'h1);
    wr(12'h000, 32'h9);
    waitEos(1);
    rdchk(12'h020, 32'h1);
    rdchk(12'h080, 32'ha0000000);
    rdchk(12'h030, 32'h1);
    rdchk(12'h038, 32'h1);
    check(irqOut, 1'b1);
    check(convCnt, 1);
    $display("single scan checked");
  endtask
  task automatic t_overflow;
    wr(12'h000, 32'h9);
    waitEos(2);
    rdchk(12'h020, 32'h3);
    rdchk(12'h080, 32'ha0000fff);
    rdchk(12'h028, 32'h3);
    wr(12'h024, 32'h0);
    wr(12'h034, 32'h0);
    rdchk(12'h028, 32'h0);
    check(irqOut, 1'b0);
    wr(12'h020, 32'h3);
    rdchk(12'h020, 32'h0);
    wr(12'h030, 32'h1);
    wr(12'h024, 32'hf);
    $display("overflow and clear checked");
  endtask
  task automatic t_range;
    wr(12'h008, 32'h5);
    wr(12'h00c, 32'h07000100);
    wr(12'h010, 32'h1);
    wr(12'h044, 32'h4);
    wr(12'h000, 32'h9);
    waitEos(3);
    rdchk(12'h040, 32'h5);
    rdchk(12'h048, 32'h4);
    rdchk(12'h088, 32'hc00005a3);
    rdchk(12'h080, 32'hc00005a2);
    wr(12'h040, 32'h5);
    $display("range and channels checked");
  endtask
  task automatic t_collide(input logic hw, input logic [31:0] flag);
    int base;
    base = eosCnt;
    wr(12'h020, 32'hf);
    wr(12'h000, 32'hb);
    if (hw) begin
      startTrig <= 1'b1;
      repeat (2) @(posedge mclk);
      startTrig <= 1'b0;
    end else
      wr(12'h000, 32'hb);
    waitEos(base + 1);
    rdchk(12'h020, 32'h1);
    waitEos(base + 2);
    rdchk(12'h020, 32'h3 | flag);
    $display("collision checked");
  endtask
  task automatic t_sync;
    int lat[2];
    int base;
    for (int s = 0; s < 2; s++) begin
      wr(12'h000, s ? 32'h2 : 32'ha);
      base = eosCnt;
      while (delayedConvClk !== 1'b0) @(posedge mclk);
      lat[s] = 0;
      startTrig <= 1'b1;
      while (sampleDone !== 1'b1 && lat[s] < 200) begin
        @(posedge mclk);
        lat[s]++;
      end
      startTrig <= 1'b0;
      waitEos(base + 1);
    end
    check(lat[0] - lat[1], 2);
    $display("trigger latency checked");
  endtask
  task automatic t_cont;
    int t[3];
    wr(12'h008, 32'h1);
    wr(12'h000, 32'hd);
    for (int k = 0; k < 3; k++) begin
      waitEos(eosCnt + 1);
      t[k] = cyc;
    end
    check(t[2] - t[1], t[1] - t[0]);
    check(t[1] - t[0], 36);
    wr(12'h000, 32'h8);
    $display("continuous scan checked");
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Whole run needs under a thousand cycles
  initial begin
    #40000;
    errors++;
    conclude();
  end
  initial begin
    repeat (6) @(posedge mclk);
    rst_b <= 1'b1;
    t_reset();
    t_scan();
    t_overflow();
    t_range();
    t_collide(1'b0, 32'h4);
    t_collide(1'b1, 32'h8);
    t_sync();
    t_cont();
    conclude();
  end
endmodule
